//--- rtl/rcd_defines.svh
// Constants for the reset and initialization sequencer of the registering clock driver.
// Summary of operation
// - In reset with nominal supply, clock-enable outputs low, parity error output high.
// - Clock-enable outputs stay low after reset until forwarding is ready.
// - Termination outputs low after release, then follow inputs within stabilization.
// - Feedback clock output stays undriven during power-up and reset.
// - After release steps, outputs follow normal registered pass-through behaviour.
// - Chip-select top index is 1 without quad mode, 3 with it.
// - In reset, input receivers are disabled and control state returns to defaults.
// - Reset input is synchronised; entering it loads reset values and floats all outputs but clock enables and parity error.
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH
`define RCD_CA_W        22
`define RCD_CLK_PS      8000
`define RCD_T_STAB_US   15
`define RCD_STAB_CYC    ((`RCD_T_STAB_US * 1000000) / `RCD_CLK_PS)
`define RCD_CNT_W       11
`define RCD_CKE_RST     4'h0
`define RCD_CS_RST      4'hF
`define RCD_ODT_RST     4'h0
`define RCD_ERR_RST     1'b1
`define RCD_PIN_W       (1 + 4 + 2 + 2 + `RCD_CA_W + 1 + 1)
`endif

//--- rtl/rcd_pkg.sv
// Types of the reset and initialization sequencer.
package rcd_pkg;
  typedef enum logic [1:0] {
    RCD_ST_RESET = 2'h0,
    RCD_ST_HOLD  = 2'h1,
    RCD_ST_STAB  = 2'h3,
    RCD_ST_RUN   = 2'h2
  } rcd_state_t;
endpackage : rcd_pkg

//--- rtl/rcd_pin_if.sv
// Synchronised pin inputs passed from the capture stage to the sequencer.
`timescale 1ns/1ns
`include "rcd_defines.svh"
interface rcd_pin_if;
  logic                 reset_n;
  logic [3:0]           chip_select_in;
  logic [1:0]           clk_enable_in;
  logic [1:0]           termination_in;
  logic [`RCD_CA_W-1:0] cmd_addr_in;
  logic                 parity_in;
  logic                 four_select_mode;
  modport cap  (output reset_n, chip_select_in, clk_enable_in, termination_in,
                output cmd_addr_in, parity_in, four_select_mode);
  modport core (input reset_n, chip_select_in, clk_enable_in, termination_in,
                input cmd_addr_in, parity_in, four_select_mode);
endinterface : rcd_pin_if

//--- rtl/rcd_pin_sync.sv
// Two-stage synchroniser for every pin input of the sequencer.
`timescale 1ns/1ns
`include "rcd_defines.svh"
module rcd_pin_sync
  import rcd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset_in_n,
  input  wire logic [3:0]           chip_select_in,
  input  wire logic [1:0]           clk_enable_in,
  input  wire logic [1:0]           termination_in,
  input  wire logic [`RCD_CA_W-1:0] cmd_addr_in,
  input  wire logic                 parity_in,
  input  wire logic                 four_select_mode,
  rcd_pin_if.cap                    pins
);
  logic [`RCD_PIN_W-1:0] meta_reg;
  logic [`RCD_PIN_W-1:0] meta_next;
  logic [`RCD_PIN_W-1:0] sync_reg;
  logic [`RCD_PIN_W-1:0] sync_next;

  // Reset is taken only after two flops, so it acts synchronously to the clock.
  always_comb begin
    meta_next = {reset_in_n, chip_select_in, clk_enable_in, termination_in,
                 cmd_addr_in, parity_in, four_select_mode};
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign {pins.reset_n, pins.chip_select_in, pins.clk_enable_in, pins.termination_in,
          pins.cmd_addr_in, pins.parity_in, pins.four_select_mode} = sync_reg;
endmodule : rcd_pin_sync

//--- rtl/rcd_init_seq.sv
// Reset and initialization sequencer that drives the register outputs.
`timescale 1ns/1ns
`include "rcd_defines.svh"
module rcd_init_seq
  import rcd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 reset_in_n,
  input  wire logic [3:0]           chip_select_in,
  input  wire logic [1:0]           clk_enable_in,
  input  wire logic [1:0]           termination_in,
  input  wire logic [`RCD_CA_W-1:0] cmd_addr_in,
  input  wire logic                 parity_in,
  input  wire logic                 four_select_mode,
  output logic      [3:0]           chip_select_out,
  output logic      [3:0]           chip_select_oe,
  output logic      [3:0]           clk_enable_out_bits,
  output logic      [3:0]           termination_out_bits,
  output logic                      termination_oe,
  output logic      [`RCD_CA_W-1:0] cmd_addr_out,
  output logic                      cmd_addr_oe,
  output logic                      parity_error_out_n,
  output logic                      parity_error_oe,
  output logic                      feedback_clk_out,
  output logic                      feedback_clk_oe
);
  rcd_pin_if pins ();

  rcd_pin_sync u_sync (
    .sys_clk          (sys_clk),
    .reset_in_n       (reset_in_n),
    .chip_select_in   (chip_select_in),
    .clk_enable_in    (clk_enable_in),
    .termination_in   (termination_in),
    .cmd_addr_in      (cmd_addr_in),
    .parity_in        (parity_in),
    .four_select_mode (four_select_mode),
    .pins             (pins)
  );

  rcd_state_t           state_reg;
  rcd_state_t           state_next;
  logic [`RCD_CNT_W-1:0] cnt_reg;
  logic [`RCD_CNT_W-1:0] cnt_next;
  logic [3:0]           cs_reg;
  logic [3:0]           cs_next;
  logic [3:0]           cs_oe_reg;
  logic [3:0]           cs_oe_next;
  logic [3:0]           cke_reg;
  logic [3:0]           cke_next;
  logic [3:0]           odt_reg;
  logic [3:0]           odt_next;
  logic                 odt_oe_reg;
  logic                 odt_oe_next;
  logic [`RCD_CA_W-1:0] ca_reg;
  logic [`RCD_CA_W-1:0] ca_next;
  logic                 ca_oe_reg;
  logic                 ca_oe_next;
  logic                 err_reg;
  logic                 err_next;
  logic                 err_oe_reg;
  logic                 err_oe_next;
  logic                 fb_reg;
  logic                 fb_next;
  logic                 fb_oe_reg;
  logic                 fb_oe_next;
  logic [3:0]           cs_map;
  logic                 one_sel;

  // Chip selects map to both output copies, or one to one in quad mode.
  always_comb begin
    if (pins.four_select_mode) begin
      cs_map  = pins.chip_select_in;
      one_sel = (cs_map == 4'hE) || (cs_map == 4'hD) || (cs_map == 4'hB) || (cs_map == 4'h7);
    end else begin
      cs_map  = {pins.chip_select_in[1:0], pins.chip_select_in[1:0]};
      one_sel = pins.chip_select_in[0] ^ pins.chip_select_in[1];
    end
  end

  // Sequence through reset, release, stabilization and normal running.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      RCD_ST_RESET: begin
        if (pins.reset_n) begin
          state_next = RCD_ST_HOLD;
        end
      end
      RCD_ST_HOLD: begin
        state_next = RCD_ST_STAB;
        cnt_next   = '0;
      end
      RCD_ST_STAB: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == `RCD_CNT_W'(`RCD_STAB_CYC - 1)) begin
          state_next = RCD_ST_RUN;
        end
      end
      RCD_ST_RUN: begin
        state_next = RCD_ST_RUN;
      end
    endcase
    if (!pins.reset_n) begin
      state_next = RCD_ST_RESET;
    end
  end

  // Output values follow the current step; inputs are ignored while in reset.
  always_comb begin
    cs_next     = `RCD_CS_RST;
    cs_oe_next  = 4'h0;
    cke_next    = `RCD_CKE_RST;
    odt_next    = `RCD_ODT_RST;
    odt_oe_next = 1'b0;
    ca_next     = '0;
    ca_oe_next  = 1'b0;
    err_next    = `RCD_ERR_RST;
    err_oe_next = 1'b1;
    fb_next     = 1'b0;
    fb_oe_next  = 1'b0;
    unique case (state_reg)
      RCD_ST_RESET: begin
        cs_oe_next = 4'h0;
      end
      RCD_ST_HOLD: begin
        cs_oe_next  = 4'hF;
        odt_oe_next = 1'b1;
        ca_oe_next  = 1'b1;
        fb_oe_next  = 1'b1;
        fb_next     = ~fb_reg;
      end
      RCD_ST_STAB: begin
        cs_oe_next  = 4'hF;
        odt_oe_next = 1'b1;
        odt_next    = {pins.termination_in, pins.termination_in};
        ca_oe_next  = 1'b1;
        ca_next     = ca_reg;
        fb_oe_next  = 1'b1;
        fb_next     = ~fb_reg;
      end
      RCD_ST_RUN: begin
        cs_oe_next  = 4'hF;
        cs_next     = cs_map;
        cke_next    = {pins.clk_enable_in, pins.clk_enable_in};
        odt_oe_next = 1'b1;
        odt_next    = {pins.termination_in, pins.termination_in};
        ca_oe_next  = 1'b1;
        ca_next     = one_sel ? pins.cmd_addr_in : ca_reg;
        fb_oe_next  = 1'b1;
        fb_next     = ~fb_reg;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= RCD_ST_RESET;
      cnt_reg    <= '0;
      cs_reg     <= `RCD_CS_RST;
      cs_oe_reg  <= 4'h0;
      cke_reg    <= `RCD_CKE_RST;
      odt_reg    <= `RCD_ODT_RST;
      odt_oe_reg <= 1'b0;
      ca_reg     <= '0;
      ca_oe_reg  <= 1'b0;
      err_reg    <= `RCD_ERR_RST;
      err_oe_reg <= 1'b1;
      fb_reg     <= 1'b0;
      fb_oe_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      cs_reg     <= cs_next;
      cs_oe_reg  <= cs_oe_next;
      cke_reg    <= cke_next;
      odt_reg    <= odt_next;
      odt_oe_reg <= odt_oe_next;
      ca_reg     <= ca_next;
      ca_oe_reg  <= ca_oe_next;
      err_reg    <= err_next;
      err_oe_reg <= err_oe_next;
      fb_reg     <= fb_next;
      fb_oe_reg  <= fb_oe_next;
    end
  end

  assign chip_select_out      = cs_reg;
  assign chip_select_oe       = cs_oe_reg;
  assign clk_enable_out_bits  = cke_reg;
  assign termination_out_bits = odt_reg;
  assign termination_oe       = odt_oe_reg;
  assign cmd_addr_out         = ca_reg;
  assign cmd_addr_oe          = ca_oe_reg;
  assign parity_error_out_n   = err_reg;
  assign parity_error_oe      = err_oe_reg;
  assign feedback_clk_out     = fb_reg;
  assign feedback_clk_oe      = fb_oe_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_in_reset;
    state_reg == RCD_ST_RESET;
  endsequence

  sequence s_release;
    state_reg == RCD_ST_RESET ##1 state_reg == RCD_ST_HOLD;
  endsequence

  a_reset_cke_err: assert property (s_in_reset |=> cke_reg == 4'h0 && err_reg && err_oe_reg)
    else $error("Clock enables or error output wrong in reset.");
  a_stab_cke_low: assert property (state_reg == RCD_ST_STAB |=> cke_reg == 4'h0)
    else $error("Clock enables rose before stabilization ended.");
  a_release_odt_low: assert property (s_release |=> odt_reg == 4'h0 && odt_oe_reg)
    else $error("Termination outputs not low right after release.");
  a_stab_odt_follow: assert property (state_reg == RCD_ST_STAB
                                      |=> odt_reg[1:0] == $past(pins.termination_in))
    else $error("Termination outputs do not follow inputs.");
  a_reset_fb_float: assert property (s_in_reset |=> !fb_oe_reg)
    else $error("Feedback clock driven during reset.");
  a_run_cke_follow: assert property (state_reg == RCD_ST_RUN
                                     |=> cke_reg[1:0] == $past(pins.clk_enable_in))
    else $error("Clock enables do not follow inputs when running.");
  a_release_to_run: assert property (s_release ##1 (pins.reset_n [*8])
                                     |-> state_reg == RCD_ST_STAB)
    else $error("Stabilization period ended too early.");
  a_dual_cs_copy: assert property (state_reg == RCD_ST_RUN && !pins.four_select_mode
                                   |=> cs_reg[3:2] == cs_reg[1:0])
    else $error("Chip select copies differ in dual mode.");
  a_enter_reset: assert property (!pins.reset_n |=> state_reg == RCD_ST_RESET
                                  ##1 cs_oe_reg == 4'h0 && !ca_oe_reg && !odt_oe_reg)
    else $error("Outputs did not float on entering reset.");
endmodule : rcd_init_seq

//--- sim/rcd_ctrl_model.sv
// Memory controller model that drives the reset and command pins of the sequencer.
`timescale 1ns/1ns
`include "rcd_defines.svh"
module rcd_ctrl_model (
  input  wire logic                 sys_clk,
  output logic                      reset_in_n,
  output logic      [3:0]           chip_select_in,
  output logic      [1:0]           clk_enable_in,
  output logic      [1:0]           termination_in,
  output logic      [`RCD_CA_W-1:0] cmd_addr_in,
  output logic                      parity_in,
  output logic                      four_select_mode
);
  initial begin
    reset_in_n       = 1'b0;
    chip_select_in   = 4'hF;
    clk_enable_in    = 2'h0;
    termination_in   = 2'h0;
    cmd_addr_in      = '0;
    parity_in        = 1'b0;
    four_select_mode = 1'b0;
  end

  // Holds reset low for n cycles; floating inputs change every cycle meanwhile.
  // Termination is left high at the end so release checks can tell low outputs from following.
  task automatic hold_reset(input int unsigned n);
    @(negedge sys_clk);
    reset_in_n     <= 1'b0;
    chip_select_in <= 4'hF;
    clk_enable_in  <= 2'h0;
    repeat (n) begin
      @(negedge sys_clk);
      cmd_addr_in    <= ~cmd_addr_in;
      termination_in <= ~termination_in;
      parity_in      <= ~parity_in;
    end
    @(negedge sys_clk);
    termination_in <= 2'h3;
  endtask : hold_reset

  // Releases reset with selects high and clock enables low.
  task automatic release_reset();
    @(negedge sys_clk);
    reset_in_n <= 1'b1;
  endtask : release_reset

  task automatic drive(input logic [3:0] cs, input logic [1:0] cke, input logic [1:0] odt,
                       input logic [`RCD_CA_W-1:0] ca, input logic quad);
    @(negedge sys_clk);
    chip_select_in   <= cs;
    clk_enable_in    <= cke;
    termination_in   <= odt;
    cmd_addr_in      <= ca;
    four_select_mode <= quad;
  endtask : drive
endmodule : rcd_ctrl_model

//--- sim/test_rcd_reset_init_sequence.sv
// Self-checking testbench of the reset and initialization sequencer.
`timescale 1ns/1ns
`include "rcd_defines.svh"
module test_rcd_reset_init_sequence;
  localparam int POWER_HOLD = 25000;
  localparam int SOFT_HOLD  = 13;
  localparam int TIMEOUT    = 40000;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 reset_in_n, parity_in, four_select_mode;
  logic [3:0]           chip_select_in, chip_select_out, chip_select_oe;
  logic [1:0]           clk_enable_in, termination_in;
  logic [3:0]           clk_enable_out_bits, termination_out_bits;
  logic [`RCD_CA_W-1:0] cmd_addr_in, cmd_addr_out;
  logic                 termination_oe, cmd_addr_oe, parity_error_out_n, parity_error_oe;
  logic                 feedback_clk_out, feedback_clk_oe;
  int                   n_fail = 0;
  int                   check_count = 0;
  int                   cycles = 0;

  always #4 sys_clk = ~sys_clk;

  rcd_ctrl_model u_rcd_ctrl_model (.sys_clk(sys_clk), .reset_in_n(reset_in_n),
    .chip_select_in(chip_select_in), .clk_enable_in(clk_enable_in),
    .termination_in(termination_in), .cmd_addr_in(cmd_addr_in), .parity_in(parity_in),
    .four_select_mode(four_select_mode));

  rcd_init_seq u_rcd_init_seq (.sys_clk(sys_clk), .rst(rst), .reset_in_n(reset_in_n),
    .chip_select_in(chip_select_in), .clk_enable_in(clk_enable_in),
    .termination_in(termination_in), .cmd_addr_in(cmd_addr_in), .parity_in(parity_in),
    .four_select_mode(four_select_mode), .chip_select_out(chip_select_out),
    .chip_select_oe(chip_select_oe), .clk_enable_out_bits(clk_enable_out_bits),
    .termination_out_bits(termination_out_bits), .termination_oe(termination_oe),
    .cmd_addr_out(cmd_addr_out), .cmd_addr_oe(cmd_addr_oe),
    .parity_error_out_n(parity_error_out_n), .parity_error_oe(parity_error_oe),
    .feedback_clk_out(feedback_clk_out), .feedback_clk_oe(feedback_clk_oe));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cycles

  task automatic final_report();
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Outputs while reset is held, after inputs have toggled.
  task automatic test_in_reset();
    check("cke", 32'h0, {28'h0, clk_enable_out_bits});
    check("err", 32'h3, {30'h0, parity_error_out_n, parity_error_oe});
    check("fb_oe", 32'h0, {31'h0, feedback_clk_oe});
    check("float", 32'h0, {26'h0, chip_select_oe, termination_oe, cmd_addr_oe});
  endtask : test_in_reset

  // Release, termination tracking during stabilization, then forwarding.
  task automatic test_release();
    u_rcd_ctrl_model.release_reset();
    wait_cycles(4);
    check("cs", 32'hFF, {24'h0, chip_select_out, chip_select_oe});
    check("odt", 32'h1, {27'h0, termination_out_bits, termination_oe});
    check("ca_oe", 32'h1, {31'h0, cmd_addr_oe});
    wait_cycles(2);
    check("odt_track", 32'h1F, {27'h0, termination_out_bits, termination_oe});
    check("cke_hold", 32'h0, {28'h0, clk_enable_out_bits});
    u_rcd_ctrl_model.drive(4'hF, 2'h0, 2'h2, '0, 1'b0);
    wait_cycles(4);
    check("odt_follow", 32'hA, {28'h0, termination_out_bits});
    wait_cycles(`RCD_STAB_CYC / 2);
    check("cke_stab", 32'h0, {28'h0, clk_enable_out_bits});
    wait_cycles(`RCD_STAB_CYC / 2 + 6);
    u_rcd_ctrl_model.drive(4'hF, 2'h1, 2'h0, '0, 1'b0);
    wait_cycles(5);
    check("cke_run", 32'h5, {28'h0, clk_enable_out_bits});
  endtask : test_release

  // Select width per mode and qualification of command forwarding.
  task automatic test_select_modes();
    logic fb_prev;
    u_rcd_ctrl_model.drive(4'h1, 2'h1, 2'h0, 22'h2AAAAA, 1'b0);
    wait_cycles(5);
    check("cs_dual", 32'h5, {28'h0, chip_select_out});
    check("ca_one", 32'h2AAAAA, {10'h0, cmd_addr_out});
    u_rcd_ctrl_model.drive(4'hF, 2'h1, 2'h0, 22'h155555, 1'b0);
    wait_cycles(5);
    check("ca_none", 32'h2AAAAA, {10'h0, cmd_addr_out});
    u_rcd_ctrl_model.drive(4'h7, 2'h1, 2'h0, 22'h155555, 1'b1);
    wait_cycles(5);
    check("cs_quad", 32'h7, {28'h0, chip_select_out});
    check("ca_quad", 32'h155555, {10'h0, cmd_addr_out});
    u_rcd_ctrl_model.drive(4'h3, 2'h1, 2'h0, 22'h3FFFFF, 1'b1);
    wait_cycles(5);
    check("ca_two", 32'h155555, {10'h0, cmd_addr_out});
    fb_prev = feedback_clk_out;
    wait_cycles(1);
    check("fb_run", {30'h0, 1'b1, ~fb_prev}, {30'h0, feedback_clk_oe, feedback_clk_out});
  endtask : test_select_modes

  // Soft reset of minimum width in mid-run, then a clean restart.
  task automatic test_soft_reset();
    u_rcd_ctrl_model.hold_reset(SOFT_HOLD);
    test_in_reset();
    test_release();
  endtask : test_soft_reset

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= TIMEOUT) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    wait_cycles(20);
    rst = 1'b0;
    u_rcd_ctrl_model.hold_reset(POWER_HOLD);
    test_in_reset();
    test_release();
    test_select_modes();
    test_soft_reset();
    final_report();
  end
endmodule : test_rcd_reset_init_sequence
